// File: hw/slr_edge_det.sv
// Synchronizer plus edge detector for the selected trigger line.
module slr_edge_det
  import slr_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Lines and selection.
  input wire logic [slr_pkg::NUM_LINES-1:0] lines_in,
  input wire logic [2:0] line_sel,
  input wire logic edge_sel,
  // Result.
  output logic strobe
);

  logic [NUM_LINES-1:0] meta_reg;
  logic [NUM_LINES-1:0] sync_reg;
  logic sel_reg;
  logic sel_next;
  logic [1:0] warm_reg;
  logic [2:0] line_q_reg;
  logic armed;
  logic rise_seen;
  logic fall_seen;

  // Two flops on every line so a change of selection never sees a metastable sample.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= lines_in;
      sync_reg <= meta_reg;
    end
  end

  // Selections at or above the line count read as low.
  assign sel_next = (line_sel < 3'(NUM_LINES)) ? sync_reg[line_sel] : 1'b0;

  // Previous sample of the selected line. The warm-up count keeps the strobe quiet until the
  // synchronizer holds real pin samples, so an idle-high line gives no false edge after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= 1'b0;
      warm_reg <= 2'h0;
      line_q_reg <= 3'h0;
    end else begin
      sel_reg <= sel_next;
      line_q_reg <= line_sel;
      if (!(&warm_reg)) begin
        warm_reg <= warm_reg + 2'h1;
      end
    end
  end

  // A change of the selected line compares two different wires, so it is not taken as an edge.
  assign armed = (&warm_reg) && (line_q_reg == line_sel);
  assign rise_seen = sel_next && !sel_reg;
  assign fall_seen = !sel_next && sel_reg;

  // Falling edge for code 0, rising for code 1.
  assign strobe = armed && ((edge_sel == EDGE_RISE) ? rise_seen : fall_seen);

endmodule

// File: hw/slr_line_mux.sv
// One board synchronization line driver.
module slr_line_mux
  import slr_pkg::*;
(
  // Selection.
  input wire logic [3:0] src_sel,
  input wire logic sw_level,
  // Candidate sources.
  input wire logic [1:0] bp_level,
  input wire logic [slr_pkg::NUM_SLOTS-1:0] slot_level,
  // Driven line.
  output logic line_out,
  output logic line_oe
);

  // Pick the source level; reserved codes leave the line undriven.
  always_comb begin
    line_out = 1'b0;
    line_oe = 1'b0;
    if (src_sel == SRC_BP0 || src_sel == SRC_BP1) begin
      line_out = bp_level[1'(src_sel - SRC_BP0)];
      line_oe = 1'b1;
    end else if (src_sel == SRC_SW) begin
      line_out = sw_level;
      line_oe = 1'b1;
    end else if (src_sel >= SRC_SLOT0 && src_sel <= SRC_SLOT5) begin
      line_out = slot_level[3'(src_sel - SRC_SLOT0)];
      line_oe = 1'b1;
    end
  end

endmodule

// File: hw/slr_pkg.sv
package slr_pkg;

  // Number of synchronization lines on the six-line carrier.
  localparam int NUM_LINES = 6;
  // Number of plug-in module slots.
  localparam int NUM_SLOTS = 6;
  // Number of analog output channels.
  localparam int NUM_CHAN = 10;
  // Width of one analog output value.
  localparam int DAC_W = 16;

  // Source selector codes for each synchronization line.
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_BP0 = 4'h1;
  localparam logic [3:0] SRC_BP1 = 4'h2;
  localparam logic [3:0] SRC_SW = 4'h3;
  localparam logic [3:0] SRC_SLOT0 = 4'h4;
  localparam logic [3:0] SRC_SLOT5 = 4'h9;

  // Synchronization mode codes.
  localparam logic SYNC_HW = 1'b0;
  localparam logic SYNC_NONE = 1'b1;
  // Trigger edge codes.
  localparam logic EDGE_FALL = 1'b0;
  localparam logic EDGE_RISE = 1'b1;

  // Register byte offsets.
  localparam logic [11:0] OFS_SRC_LO = 12'h000;
  localparam logic [11:0] OFS_SRC_HI = 12'h004;
  localparam logic [11:0] OFS_LEVEL = 12'h008;
  localparam logic [11:0] OFS_UPD_CFG = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_CHAN0 = 12'h040;

  // Field positions in the update configuration register.
  localparam int CFG_MODE_BIT = 0;
  localparam int CFG_EDGE_BIT = 1;
  localparam int CFG_SRC_LSB = 4;
  localparam int CFG_SRC_W = 3;
  localparam int CFG_FOUR_BIT = 8;

  // Reset values.
  localparam logic [3:0] RST_SRC = SRC_NONE;
  localparam logic [NUM_LINES-1:0] RST_LEVEL = 6'h00;
  localparam logic RST_MODE = SYNC_NONE;
  localparam logic RST_EDGE = EDGE_FALL;
  localparam logic [2:0] RST_TRIG_SRC = 3'h0;

  // Update trigger configuration travelling as one unit.
  typedef struct packed {
    logic mode;
    logic edge_sel;
    logic [2:0] line_sel;
    logic four_line;
  } slr_trig_cfg_t;

endpackage

// File: hw/slr_top.sv
module slr_top
  import slr_pkg::*;
#(
  parameter int CHANNELS = slr_pkg::NUM_CHAN
) (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Backplane synchronization lines.
  input wire logic [1:0] bp_sync_in,
  // Plug-in slot drive requests, one level per slot.
  input wire logic [slr_pkg::NUM_SLOTS-1:0] slot_drive,
  // Board synchronization lines as three signals each.
  input wire logic [slr_pkg::NUM_LINES-1:0] line_in,
  output logic [slr_pkg::NUM_LINES-1:0] line_out,
  output logic [slr_pkg::NUM_LINES-1:0] line_oe,
  // Applied analog output values.
  output logic [CHANNELS*slr_pkg::DAC_W-1:0] dac_out,
  output logic dac_update
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronizers.

  // Two flops per outside level; only the second one is read by logic.
  logic [1:0] bp_meta_reg;
  logic [1:0] bp_sync_reg;
  logic [NUM_SLOTS-1:0] slot_meta_reg;
  logic [NUM_SLOTS-1:0] slot_sync_reg;
  logic [NUM_LINES-1:0] line_meta_reg;
  logic [NUM_LINES-1:0] line_sync_reg;

  // Backplane and slot levels come from outside this clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bp_meta_reg <= '0;
      bp_sync_reg <= '0;
      slot_meta_reg <= '0;
      slot_sync_reg <= '0;
    end else begin
      bp_meta_reg <= bp_sync_in;
      bp_sync_reg <= bp_meta_reg;
      slot_meta_reg <= slot_drive;
      slot_sync_reg <= slot_meta_reg;
    end
  end

  // Board wire levels for the status view; the trigger path keeps its own pair.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_meta_reg <= '0;
      line_sync_reg <= '0;
    end else begin
      line_meta_reg <= line_in;
      line_sync_reg <= line_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  // Settings written by software.
  logic [3:0] src_sel_reg [NUM_LINES];
  logic [NUM_LINES-1:0] line_level_bit_reg;
  slr_trig_cfg_t trig_cfg_reg;
  // Output values: pending copies take writes, live copies drive the outputs.
  logic [DAC_W-1:0] pend_reg [CHANNELS];
  logic [DAC_W-1:0] live_reg [CHANNELS];
  // Bus decode and trigger helpers.
  logic pending_reg;
  logic wr_en;
  logic rd_en;
  logic chan_hit;
  logic [11:0] chan_ofs;
  logic [11:0] chan_idx;
  logic addr_ok;
  logic trig_strobe;
  logic apply_now;

  // Access-phase decode; the channel window is word aligned and CHANNELS words long.
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign chan_ofs = paddr - OFS_CHAN0;
  assign chan_idx = {2'b00, chan_ofs[11:2]};
  assign chan_hit = (paddr >= OFS_CHAN0) && (chan_idx < 12'(CHANNELS)) && (paddr[1:0] == 2'b00);

  // Zero wait states keep the bus simple; every access finishes in its first access cycle.
  assign pready = 1'b1;

  // Decode which offsets exist.
  // Only word-aligned offsets of real registers are mapped.
  always_comb begin
    addr_ok = chan_hit;
    if (paddr == OFS_SRC_LO || paddr == OFS_SRC_HI || paddr == OFS_LEVEL ||
        paddr == OFS_UPD_CFG || paddr == OFS_STATUS) begin
      addr_ok = 1'b1;
    end
  end

  // Unmapped offsets answer with an error; writes there change nothing.
  assign pslverr = psel && penable && !addr_ok;

  // Source selectors, four bits per line, written live while running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        src_sel_reg[i] <= RST_SRC;
      end
    end else if (wr_en && paddr == OFS_SRC_LO) begin
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i/2]) begin
          src_sel_reg[i] <= pwdata[i*4 +: 4];
        end
      end
    end else if (wr_en && paddr == OFS_SRC_HI && pstrb[0]) begin
      src_sel_reg[4] <= pwdata[3:0];
      src_sel_reg[5] <= pwdata[7:4];
    end
  end

  // Software level bits, one per line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_level_bit_reg <= RST_LEVEL;
    end else if (wr_en && paddr == OFS_LEVEL && pstrb[0]) begin
      line_level_bit_reg <= pwdata[NUM_LINES-1:0];
    end
  end

  // Update trigger configuration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_cfg_reg.mode <= RST_MODE;
      trig_cfg_reg.edge_sel <= RST_EDGE;
      trig_cfg_reg.line_sel <= RST_TRIG_SRC;
      trig_cfg_reg.four_line <= 1'b0;
    end else if (wr_en && paddr == OFS_UPD_CFG) begin
      if (pstrb[0]) begin
        trig_cfg_reg.mode <= pwdata[CFG_MODE_BIT];
        trig_cfg_reg.edge_sel <= pwdata[CFG_EDGE_BIT];
        trig_cfg_reg.line_sel <= pwdata[CFG_SRC_LSB +: CFG_SRC_W];
      end
      if (pstrb[1]) begin
        trig_cfg_reg.four_line <= pwdata[CFG_FOUR_BIT];
      end
    end
  end

  // Read mux. Data is driven only in the access phase, so an idle bus reads zero.
  // The status word shows synchronized line levels, never raw pins.
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      if (paddr == OFS_SRC_LO) begin
        prdata = {16'h0000, src_sel_reg[3], src_sel_reg[2], src_sel_reg[1], src_sel_reg[0]};
      end else if (paddr == OFS_SRC_HI) begin
        prdata = {24'h000000, src_sel_reg[5], src_sel_reg[4]};
      end else if (paddr == OFS_LEVEL) begin
        prdata = {26'h0, line_level_bit_reg};
      end else if (paddr == OFS_UPD_CFG) begin
        prdata = {23'h0, trig_cfg_reg.four_line, 1'b0, trig_cfg_reg.line_sel,
                  2'b00, trig_cfg_reg.edge_sel, trig_cfg_reg.mode};
      end else if (paddr == OFS_STATUS) begin
        prdata = {17'h0, pending_reg, 2'b00, line_oe, 6'h00} | {26'h0, line_sync_reg};
      end else if (chan_hit) begin
        prdata = {16'h0000, live_reg[chan_idx[3:0]]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line drivers, one independent selector per line.

  // Lines 4 and 5 exist even for a four-line board; their drivers idle unless selected.
  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_line
      // Each line has its own selector and level bit, so lines never interact.
      slr_line_mux u_mux (
        .src_sel(src_sel_reg[g]),
        .sw_level(line_level_bit_reg[g]),
        .bp_level(bp_sync_reg),
        .slot_level(slot_sync_reg),
        .line_out(line_out[g]),
        .line_oe(line_oe[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Update trigger.

  // Line actually watched; code 7 points past the last line and reads as low.
  logic [2:0] eff_line;

  // A four-line board has no lines 4 and 5; such a choice never triggers.
  assign eff_line = (trig_cfg_reg.four_line && trig_cfg_reg.line_sel > 3'h3) ?
                    3'h7 : trig_cfg_reg.line_sel;

  // The detector synchronizes the wires itself, so it sees the line as the slots see it.
  slr_edge_det u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .lines_in(line_in),
    .line_sel(eff_line),
    .edge_sel(trig_cfg_reg.edge_sel),
    .strobe(trig_strobe)
  );

  // In unsynchronized mode the trigger is ignored and writes apply directly.
  // A strobe with nothing pending does nothing, so idle edges never pulse dac_update.
  assign apply_now = (trig_cfg_reg.mode == SYNC_HW) && trig_strobe && pending_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Output value staging.

  // Pending values take every write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        pend_reg[i] <= '0;
      end
    end else if (wr_en && chan_hit) begin
      if (pstrb[0]) begin
        pend_reg[chan_idx[3:0]][7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        pend_reg[chan_idx[3:0]][15:8] <= pwdata[15:8];
      end
    end
  end

  // A write and a trigger in the same cycle: the write stays pending for the next edge.
  // Leaving triggered mode drops the flag; values still pending are not applied.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= 1'b0;
    end else if (wr_en && chan_hit && trig_cfg_reg.mode == SYNC_HW) begin
      pending_reg <= 1'b1;
    end else if (apply_now || trig_cfg_reg.mode == SYNC_NONE) begin
      pending_reg <= 1'b0;
    end
  end

  // Live values: immediate in unsynchronized mode, all channels at once on a trigger.
  // The update flag is registered with the live values, so it stands in the same cycle that they change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        live_reg[i] <= '0;
      end
      dac_update <= 1'b0;
    end else begin
      dac_update <= 1'b0;
      if (trig_cfg_reg.mode == SYNC_NONE && wr_en && chan_hit) begin
        if (pstrb[0]) begin
          live_reg[chan_idx[3:0]][7:0] <= pwdata[7:0];
        end
        if (pstrb[1]) begin
          live_reg[chan_idx[3:0]][15:8] <= pwdata[15:8];
        end
        dac_update <= 1'b1;
      end else if (apply_now) begin
        for (int i = 0; i < CHANNELS; i++) begin
          live_reg[i] <= pend_reg[i];
        end
        dac_update <= 1'b1;
      end
    end
  end

  // Flatten the live values onto the output bus.
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      dac_out[i*DAC_W +: DAC_W] = live_reg[i];
    end
  end

endmodule

// File: tb/slr_far_side.sv
module slr_far_side
  import slr_pkg::*;
(
  // Clock and bench commands.
  input wire logic pclk,
  input wire logic [1:0] bp_cmd,
  input wire logic [slr_pkg::NUM_SLOTS-1:0] slot_cmd,
  // Board wires.
  input wire logic [slr_pkg::NUM_LINES-1:0] line_out,
  input wire logic [slr_pkg::NUM_LINES-1:0] line_oe,
  output logic [1:0] bp_sync_in,
  output logic [slr_pkg::NUM_SLOTS-1:0] slot_drive,
  output logic [slr_pkg::NUM_LINES-1:0] line_in
);
  logic [slr_pkg::NUM_LINES-1:0] last_q = '0;
  // Backplane and slots change just after an edge, as real drivers would.
  always_ff @(posedge pclk) begin
    bp_sync_in <= bp_cmd;
    slot_drive <= slot_cmd;
  end
  // Keep the last driven level; a released line must not look still driven.
  // Only known drive updates the memory, so lines never driven keep a clean level.
  always_ff @(posedge pclk) begin
    for (int i = 0; i < slr_pkg::NUM_LINES; i++) begin
      if (line_oe[i]) last_q[i] <= line_out[i];
    end
  end
  // Each wire resolves on its own, so one can be driven while another is watched.
  assign line_in = (line_oe & line_out) | (~line_oe & ~last_q);
endmodule

// File: tb/slr_props.sv
module slr_props
  import slr_pkg::*;
#(
  parameter int CHANNELS = slr_pkg::NUM_CHAN
) (
  // Bus side.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // Lines and outputs.
  input wire logic [1:0] bp_sync_in,
  input wire logic [slr_pkg::NUM_LINES-1:0] line_in,
  input wire logic [slr_pkg::NUM_LINES-1:0] line_out,
  input wire logic [slr_pkg::NUM_LINES-1:0] line_oe,
  input wire logic [CHANNELS*slr_pkg::DAC_W-1:0] dac_out,
  input wire logic dac_update
);
  logic wr;
  logic mode_q;
  logic [1:0] lvl_q;
  logic [3:0] src0_q;
  logic [3:0] src1_q;
  logic [3:0] quiet_q;
  logic [slr_pkg::NUM_LINES-1:0] prev_q;
  assign wr = psel && penable && pwrite;
  // Shadow of the settings, rebuilt from bus traffic alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= RST_MODE;
      lvl_q <= 2'h0;
      src0_q <= RST_SRC;
      src1_q <= RST_SRC;
    end else if (wr && pstrb[0]) begin
      if (paddr == OFS_UPD_CFG) mode_q <= pwdata[CFG_MODE_BIT];
      if (paddr == OFS_LEVEL) lvl_q <= pwdata[1:0];
      if (paddr == OFS_SRC_LO) src0_q <= pwdata[3:0];
      if (paddr == OFS_SRC_LO) src1_q <= pwdata[7:4];
    end
  end
  // Cycles with no write and no line change; without one, no update may happen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_q <= 4'h0;
      prev_q <= '0;
    end else begin
      prev_q <= line_in;
      if (wr || line_in != prev_q) quiet_q <= 4'h0;
      else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence chan0_wr;
    wr && paddr == OFS_CHAN0 && pstrb[1:0] == 2'h3;
  endsequence
  sequence pick_sw0;
    wr && paddr == OFS_SRC_LO && pstrb[0] && pwdata[3:0] == SRC_SW;
  endsequence
  chk_none_quiet: assert property (src0_q == SRC_NONE |-> !line_oe[0])
    else $error("line 0 driven with no source");
  chk_bp_follow: assert property (src0_q == SRC_BP0 |-> line_oe[0] &&
    line_out[0] == $past(bp_sync_in[0], 2)) else $error("line 0 not following backplane");
  chk_sw_level: assert property (src0_q == SRC_SW |-> line_oe[0] && line_out[0] == lvl_q[0])
    else $error("line 0 not at its level bit");
  chk_own_bit: assert property (src1_q == SRC_SW |-> line_oe[1] && line_out[1] == lvl_q[1])
    else $error("line 1 not at its own level bit");
  chk_sel_at_once: assert property (pick_sw0 |=> line_oe[0])
    else $error("source change not taken at once");
  chk_nosync_apply: assert property ((mode_q == SYNC_NONE) ##0 chan0_wr |=>
    (dac_out[15:0] == $past(pwdata[15:0])) ##[0:1] dac_update) else $error("value not applied");
  chk_hold_pending: assert property (quiet_q >= 4'h6 && mode_q == SYNC_HW |-> !dac_update)
    else $error("update without trigger edge");
  chk_pulse_single: assert property (mode_q == SYNC_HW && dac_update |=> !dac_update)
    else $error("update strobe longer than one cycle");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind slr_top slr_props #(.CHANNELS(CHANNELS)) i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .bp_sync_in(bp_sync_in), .line_in(line_in), .line_out(line_out),
  .line_oe(line_oe), .dac_out(dac_out), .dac_update(dac_update));

// File: tb/slr_top_tb_top.sv
module slr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import slr_pkg::*;
  typedef struct packed {
    logic [3:0] src;
    logic [1:0] bp;
    logic [5:0] slot;
    logic lvl;
    logic [1:0] exp;
  } slr_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic [1:0] bp_cmd = '0;
  logic [5:0] slot_cmd = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, dac_update;
  logic [1:0] bp_sync_in;
  logic [5:0] slot_drive, line_in, line_out, line_oe;
  logic [NUM_CHAN*DAC_W-1:0] dac_out;
  int fail_count = 0;
  int cmp_count = 0;
  int upd_cnt = 0;
  int cyc = 0;
  // Ordinary line-source cases; exp is {driven, driven high}.
  slr_row_t rows [8] = '{'{SRC_NONE, 2'h3, 6'h3F, 1'b1, 2'h0}, '{SRC_BP0, 2'h1, 6'h00, 1'b0, 2'h3},
    '{SRC_BP0, 2'h2, 6'h3F, 1'b1, 2'h2}, '{SRC_BP1, 2'h2, 6'h00, 1'b0, 2'h3},
    '{SRC_BP1, 2'h1, 6'h00, 1'b1, 2'h2}, '{SRC_SW, 2'h3, 6'h3F, 1'b0, 2'h2},
    '{SRC_SW, 2'h0, 6'h00, 1'b1, 2'h3}, '{4'hA, 2'h3, 6'h3F, 1'b1, 2'h0}};
  always #20 pclk = ~pclk;
  slr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bp_sync_in(bp_sync_in), .slot_drive(slot_drive),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .dac_out(dac_out),
    .dac_update(dac_update));
  slr_far_side i_far (.pclk(pclk), .bp_cmd(bp_cmd), .slot_cmd(slot_cmd),
    .line_out(line_out), .line_oe(line_oe), .bp_sync_in(bp_sync_in),
    .slot_drive(slot_drive), .line_in(line_in));
  // Count strobes and cycles; the run needs well under 2000 cycles.
  always @(posedge pclk) begin
    cyc++;
    if (dac_update === 1'b1) upd_cnt++;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One bus transfer; an idle cycle follows so back-to-back calls never collide.
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the slave; only the cycle watchdog ends a hung transfer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic apply_row(input slr_row_t r);
    bp_cmd <= r.bp;
    slot_cmd <= r.slot;
    xfer(OFS_LEVEL, 1'b1, {31'h0, r.lvl});
    xfer(OFS_SRC_LO, 1'b1, {28'h0, r.src});
    check({30'h0, line_oe[0], line_oe[0] & line_out[0]}, {30'h0, r.exp}, "line 0");
  endtask
  task automatic settle_check(input int ch, input logic [15:0] v, input int n);
    repeat (8) @(posedge pclk);
    check({16'h0, dac_out[ch*DAC_W +: DAC_W]}, {16'h0, v}, "channel value");
    check(upd_cnt, n, "update count");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    check({dac_out[31:0]}, 32'h0, "reset values");
    check({26'h0, line_oe}, 32'h0, "reset drive");
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(OFS_UPD_CFG, 1'b0, 32'h0);
    check(rd, 32'h1, "config reset");
    xfer(12'h020, 1'b0, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped");
    $display("reset test done");
    foreach (rows[i]) apply_row(rows[i]);
    for (int k = 0; k < 6; k++) begin
      apply_row('{SRC_SLOT0 + 4'(k), 2'h3, 6'h3F ^ (6'h01 << k), 1'b1, 2'h2});
      apply_row('{SRC_SLOT0 + 4'(k), 2'h0, 6'h01 << k, 1'b0, 2'h3});
    end
    $display("line source test done");
    xfer(OFS_CHAN0, 1'b1, 32'hA5C3);
    check({16'h0, dac_out[15:0]}, 32'hA5C3, "direct apply");
    // Line 1 under software control triggers on its rising edge.
    xfer(OFS_SRC_LO, 1'b1, 32'h30);
    xfer(OFS_LEVEL, 1'b1, 32'h0);
    xfer(OFS_UPD_CFG, 1'b1, 32'h12);
    xfer(OFS_CHAN0, 1'b1, 32'h1234);
    xfer(12'h064, 1'b1, 32'hBEEF);
    settle_check(0, 16'hA5C3, 1);
    xfer(OFS_LEVEL, 1'b1, 32'h2);
    settle_check(0, 16'h1234, 2);
    check({16'h0, dac_out[9*DAC_W +: DAC_W]}, 32'hBEEF, "all channels");
    xfer(OFS_CHAN0, 1'b1, 32'h5555);
    xfer(OFS_LEVEL, 1'b1, 32'h0);
    // Pending set, line 1 driven low, line 0 released after a high, lines 2-5 never driven.
    xfer(OFS_STATUS, 1'b0, 32'h0);
    check(rd, 32'h0000_40BC, "status word");
    settle_check(0, 16'h1234, 2);
    xfer(OFS_UPD_CFG, 1'b1, 32'h10);
    xfer(OFS_LEVEL, 1'b1, 32'h2);
    xfer(OFS_LEVEL, 1'b1, 32'h0);
    settle_check(0, 16'h5555, 3);
    $display("trigger edge test done");
    // Line 4 is refused on a four-line board, then accepted on six lines.
    xfer(OFS_SRC_HI, 1'b1, 32'h3);
    xfer(OFS_UPD_CFG, 1'b1, 32'h142);
    xfer(12'h044, 1'b1, 32'h7777);
    xfer(OFS_LEVEL, 1'b1, 32'h10);
    settle_check(1, 16'h0, 3);
    // Lower line 4 first so that only a real pin edge can apply the pending value.
    xfer(OFS_LEVEL, 1'b1, 32'h0);
    xfer(OFS_UPD_CFG, 1'b1, 32'h42);
    xfer(OFS_LEVEL, 1'b1, 32'h10);
    settle_check(1, 16'h7777, 4);
    xfer(OFS_UPD_CFG, 1'b1, 32'h43);
    xfer(12'h048, 1'b1, 32'h2222);
    check({16'h0, dac_out[2*DAC_W +: DAC_W]}, 32'h2222, "unsynced ignores trigger");
    // Edges on the configured line must not add updates while unsynchronized.
    xfer(OFS_LEVEL, 1'b1, 32'h0);
    xfer(OFS_LEVEL, 1'b1, 32'h10);
    settle_check(2, 16'h2222, 5);
    $display("trigger source test done");
    tally_and_finish();
  end
endmodule
